// ### design/swp_pkg.sv
package swp_pkg;

  // ****************************************
  // Message geometry
  // ****************************************
  localparam int SWP_NCH   = 4;
  localparam int SWP_NLANE = 16;
  localparam int SWP_DW    = 32;
  localparam int SWP_RDW   = 8;

  // ****************************************
  // Fixed fill patterns and dword 0 enable of the mask registers, step counter reset value
  // ****************************************
  localparam logic [15:0] SWP_HI16    = 16'hffff;
  localparam logic [7:0]  SWP_HI8     = 8'hff;
  localparam logic [23:0] SWP_HI24    = 24'hffffff;
  localparam logic [29:0] SWP_HI30    = 30'h3fffffff;
  localparam logic [7:0]  SWP_DW0_EN  = 8'h01;
  localparam logic [3:0]  SWP_STEP_RST = 4'h0;

  // ****************************************
  // Types
  // ****************************************
  typedef enum logic [1:0] {
    SWP_M16   = 2'b00,
    SWP_M8    = 2'b01,
    SWP_M4X2  = 2'b10,
    SWP_M3264 = 2'b11
  } swp_mode_t;

  typedef enum logic [1:0] {
    SWP_F_FLOAT = 2'b00,
    SWP_F_S31   = 2'b01,
    SWP_F_U32   = 2'b10,
    SWP_F_RSVD  = 2'b11
  } swp_fmt_t;

  typedef enum logic {
    SWP_IDLE = 1'b0,
    SWP_SEND = 1'b1
  } swp_state_t;

  typedef struct packed {
    swp_mode_t   mode;
    swp_fmt_t    fmt;
    logic [3:0]  wmask;
    logic [15:0] execution_lane_mask;
    logic [7:0]  dst;
    logic        fault_en;
    logic        kill_en;
    logic [15:0] fault_ok;
    logic [15:0] kill_ok;
  } swp_req_t;

  typedef logic [3:0][15:0][31:0] swp_texel_t;

endpackage

// ### design/swp_packer.sv
`timescale 1ns/1ps
`default_nettype none

module swp_packer
  import swp_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       rst_b,
  input  wire logic       req_valid,
  output logic            req_ready,
  input  wire swp_req_t   req,
  input  wire swp_texel_t req_texel,
  output logic            wb_valid_ff,
  output logic [7:0]      wb_idx_ff,
  output logic [255:0]    wb_data_ff,
  output logic [7:0]      wb_wen_ff,
  output logic            wb_last_ff,
  output swp_fmt_t        wb_fmt_ff
);

  // ****************************************
  // Helpers
  // ****************************************
  // Index of the k-th enabled channel, counting from red
  function automatic logic [1:0] swp_nth(
    input logic [3:0] m,
    input logic [2:0] k
  );
    logic [2:0] n;
    logic [1:0] r;
    n = 3'd0;
    r = 2'd0;
    for (int c = 0; c < SWP_NCH; c++) begin
      if (m[c]) begin
        if (n == k) begin
          r = c[1:0];
        end
        n = n + 3'd1;
      end
    end
    return r;
  endfunction

  function automatic logic [2:0] swp_pop(input logic [3:0] m);
    return {2'b00, m[0]} + {2'b00, m[1]} + {2'b00, m[2]} + {2'b00, m[3]};
  endfunction

  // ****************************************
  // Request capture
  // ****************************************
  swp_state_t state_ff;
  swp_state_t nxt_state;
  swp_req_t   req_ff;
  swp_texel_t tex_ff;
  logic [3:0] step_ff;
  logic [3:0] last_ff;
  logic [3:0] ncol_ff;
  logic [3:0] nxt_ncol;
  logic [3:0] nxt_total;
  logic       take;

  assign req_ready = (state_ff == SWP_IDLE);
  assign take      = req_valid && req_ready;

  // Color register count and extra mask registers per layout
  always_comb begin
    nxt_ncol  = 4'd0;
    nxt_total = 4'd0;
    case (req.mode)
      SWP_M16: begin
        nxt_ncol  = {swp_pop(req.wmask), 1'b0};
        nxt_total = nxt_ncol + {3'd0, req.fault_en};
      end
      SWP_M8: begin
        nxt_ncol  = 4'd4;
        nxt_total = nxt_ncol + {3'd0, req.kill_en} + {3'd0, req.fault_en};
      end
      SWP_M4X2: begin
        nxt_ncol  = 4'd1;
        nxt_total = nxt_ncol + {3'd0, req.fault_en};
      end
      default: begin
        // Wide media layouts are not packed here; one empty register
        // still closes the response so the thread is never left waiting
        nxt_ncol  = 4'd1;
        nxt_total = 4'd1;
      end
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state_ff <= SWP_IDLE;
    end else begin
      state_ff <= nxt_state;
    end
  end

  always_comb begin
    nxt_state = state_ff;
    case (state_ff)
      SWP_IDLE: begin
        if (take) begin
          nxt_state = SWP_SEND;
        end
      end
      SWP_SEND: begin
        if (step_ff == last_ff) begin
          nxt_state = SWP_IDLE;
        end
      end
      default: nxt_state = SWP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      req_ff  <= '0;
      tex_ff  <= '0;
      ncol_ff <= SWP_STEP_RST;
      last_ff <= SWP_STEP_RST;
    end else if (take) begin
      req_ff  <= req;
      tex_ff  <= req_texel;
      ncol_ff <= nxt_ncol;
      // An all-masked SIMD16 request with fault_en clear still answers with one empty register
      last_ff <= (nxt_total == 4'd0) ? 4'd0 : nxt_total - 4'd1;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      step_ff <= SWP_STEP_RST;
    end else if (take) begin
      step_ff <= SWP_STEP_RST;
    end else if (state_ff == SWP_SEND) begin
      step_ff <= step_ff + 4'd1;
    end
  end

  // ****************************************
  // Register content for the current step
  // ****************************************
  logic [7:0][31:0] nxt_data;
  logic [7:0]       nxt_wen;
  logic [1:0]       ch;
  logic             half;
  logic [3:0]       mstep;
  logic [1:0]       act;

  assign ch    = swp_nth(req_ff.wmask, step_ff[3:1]);
  assign half  = step_ff[0];
  assign mstep = step_ff - ncol_ff;
  assign act   = {|req_ff.execution_lane_mask[7:4],
                  |req_ff.execution_lane_mask[3:0]};

  always_comb begin
    nxt_data = '0;
    nxt_wen  = 8'h00;
    if (step_ff < ncol_ff) begin
      case (req_ff.mode)
        SWP_M16: begin
          for (int i = 0; i < SWP_RDW; i++) begin
            // Values pass untouched: the pipeline already encodes them
            nxt_data[i] = tex_ff[ch][{half, i[2:0]}];
          end
          nxt_wen = half ? req_ff.execution_lane_mask[15:8]
                         : req_ff.execution_lane_mask[7:0];
        end
        SWP_M8: begin
          for (int i = 0; i < SWP_RDW; i++) begin
            nxt_data[i] = tex_ff[step_ff[1:0]][i];
          end
          nxt_wen = req_ff.wmask[step_ff[1:0]] ?
                    req_ff.execution_lane_mask[7:0] : 8'h00;
        end
        SWP_M4X2: begin
          for (int i = 0; i < SWP_RDW; i++) begin
            nxt_data[i] = tex_ff[i[1:0]][{3'd0, i[2]}];
            nxt_wen[i]  = req_ff.wmask[i[1:0]] & act[i[2]];
          end
        end
        default: begin
          nxt_wen = 8'h00;
        end
      endcase
    end else begin
      // Mask registers: only dword 0 is written, dwords 7:1 are kept
      if (req_ff.mode == SWP_M8 && req_ff.kill_en && mstep == 4'd0) begin
        nxt_data[0] = {SWP_HI16, SWP_HI8, req_ff.kill_ok[7:0]};
        nxt_wen     = SWP_DW0_EN;
      end else if (req_ff.fault_en) begin
        nxt_wen = SWP_DW0_EN;
        case (req_ff.mode)
          SWP_M16: nxt_data[0] = {SWP_HI16, req_ff.fault_ok};
          SWP_M8: nxt_data[0] = {SWP_HI24, req_ff.fault_ok[7:0]};
          SWP_M4X2: nxt_data[0] = {SWP_HI30, req_ff.fault_ok[1:0]};
          default: nxt_wen = 8'h00;
        endcase
      end
    end
  end

  // ****************************************
  // Writeback outputs
  // ****************************************
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_valid_ff <= 1'b0;
      wb_last_ff  <= 1'b0;
    end else begin
      wb_valid_ff <= (state_ff == SWP_SEND);
      wb_last_ff  <= (state_ff == SWP_SEND) && (step_ff == last_ff);
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      wb_idx_ff  <= '0;
      wb_data_ff <= '0;
      wb_wen_ff  <= '0;
      wb_fmt_ff  <= SWP_F_FLOAT;
    end else if (state_ff == SWP_SEND) begin
      wb_idx_ff  <= req_ff.dst + {4'd0, step_ff};
      wb_data_ff <= nxt_data;
      wb_wen_ff  <= nxt_wen;
      wb_fmt_ff  <= req_ff.fmt;
    end else begin
      // No write can leak out between responses
      wb_wen_ff  <= 8'h00;
    end
  end

endmodule // swp_packer

`default_nettype wire

// ### dv/swp_packer_sva.sv
`timescale 1ns/1ps
`default_nettype none
module swp_packer_sva
  import swp_pkg::*;
(
  input wire logic         clk,
  input wire logic         rst_b,
  input wire logic         req_valid,
  input wire logic         req_ready,
  input wire swp_req_t     req,
  input wire swp_texel_t   req_texel,
  input wire logic         wb_valid_ff,
  input wire logic [7:0]   wb_idx_ff,
  input wire logic [255:0] wb_data_ff,
  input wire logic [7:0]   wb_wen_ff,
  input wire logic         wb_last_ff,
  input wire swp_fmt_t     wb_fmt_ff
);
  // ********
  // Checks
  // ********
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire tk = req_valid && req_ready;
  wire m16 = tk && req.mode == SWP_M16;
  property p_resp; tk |-> ##2 wb_valid_ff; endproperty
  a_resp: assert property (p_resp) else $error("no response");
  property p_idx; tk |-> ##2 wb_idx_ff == $past(req.dst, 2); endproperty
  a_idx: assert property (p_idx) else $error("bad first index");
  property p_seq;
    wb_valid_ff && !wb_last_ff |=> wb_valid_ff
      && wb_idx_ff == $past(wb_idx_ff) + 8'h01;
  endproperty
  a_seq: assert property (p_seq) else $error("gap in response");
  property p_fmt; tk |-> ##2 wb_fmt_ff == $past(req.fmt, 2); endproperty
  a_fmt: assert property (p_fmt) else $error("format lost");
  property p_idle; !wb_valid_ff |-> wb_wen_ff == 8'h00; endproperty
  a_idle: assert property (p_idle) else $error("stray enable");
  // Pair halves follow the lane mask halves in order
  property p_s16wen;
    m16 && req.wmask[0] |-> ##2
      wb_wen_ff == $past(req.execution_lane_mask[7:0], 2)
      ##1 wb_wen_ff == $past(req.execution_lane_mask[15:8], 3);
  endproperty
  a_s16wen: assert property (p_s16wen) else $error("pair enables");
  property p_s16f;
    m16 && req.wmask == 4'h0 && req.fault_en |-> ##2 wb_last_ff
      && wb_wen_ff == SWP_DW0_EN
      && wb_data_ff[31:0] == {SWP_HI16, $past(req.fault_ok, 2)};
  endproperty
  a_s16f: assert property (p_s16f) else $error("fault register");
  property p_s8len;
    tk && req.mode == SWP_M8 && !req.kill_en && !req.fault_en
      |-> ##2 (wb_valid_ff && !wb_last_ff)[*3] ##1 wb_last_ff;
  endproperty
  a_s8len: assert property (p_s8len) else $error("simd8 length");
  property p_s4;
    tk && req.mode == SWP_M4X2 && !req.fault_en |-> ##2 wb_last_ff;
  endproperty
  a_s4: assert property (p_s4) else $error("simd4x2 length");
  c_s16: cover property (m16 && req.fault_en);
  c_kill: cover property (tk && req.mode == SWP_M8 && req.kill_en);
  c_s4: cover property (tk && req.mode == SWP_M4X2 && req.fault_en);
endmodule // swp_packer_sva
bind swp_packer swp_packer_sva i_swp_packer_sva (.clk, .rst_b, .req_valid,
  .req_ready, .req, .req_texel, .wb_valid_ff, .wb_idx_ff, .wb_data_ff,
  .wb_wen_ff, .wb_last_ff, .wb_fmt_ff);
`default_nettype wire

// ### dv/swp_rf_model.sv
`timescale 1ns/1ps
`default_nettype none
module swp_rf_model (
  input wire logic         clk,
  input wire logic         wb_valid,
  input wire logic [7:0]   idx,
  input wire logic [255:0] data,
  input wire logic [7:0]   wen
);
  logic [255:0] regs [256];
  // Known filler so that any unwanted write shows up
  initial foreach (regs[i]) regs[i] = {8{32'h5a5a5a5a}};
  always @(posedge clk)
    if (wb_valid)
      for (int i = 0; i < 8; i++)
        if (wen[i]) regs[idx][i*32+:32] <= data[i*32+:32];
  // Thread-side patch of the returned active pixel mask
  function automatic logic [15:0] fixed_mask(
    input int          r,
    input logic [15:0] execution_lane_mask,
    input logic [15:0] launch_lane_mask
  );
    return (regs[r][15:0] | ~execution_lane_mask) & launch_lane_mask;
  endfunction
endmodule // swp_rf_model
`default_nettype wire

// ### dv/test_swp_packer.sv
`timescale 1ns/1ps
`default_nettype none
module test_swp_packer
  import swp_pkg::*;
;
  localparam logic [31:0] K = 32'h5a5a5a5a;
  logic clk, rst_b, req_valid, req_ready, wb_valid_ff, wb_last_ff;
  logic [7:0]   wb_idx_ff, wb_wen_ff;
  logic [255:0] wb_data_ff;
  swp_req_t     req;
  swp_texel_t   req_texel;
  swp_fmt_t     wb_fmt_ff;
  int num_errors = 0;
  int checks_done = 0;
  swp_packer i_swp_packer (.clk, .rst_b, .req_valid, .req_ready, .req,
    .req_texel, .wb_valid_ff, .wb_idx_ff, .wb_data_ff, .wb_wen_ff,
    .wb_last_ff, .wb_fmt_ff);
  swp_rf_model i_swp_rf_model (.clk, .wb_valid(wb_valid_ff),
    .idx(wb_idx_ff), .data(wb_data_ff), .wen(wb_wen_ff));
  initial begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  function automatic logic [31:0] t(int c, int l);
    return 32'ha00000 + 32'(c * 256 + l);
  endfunction
  function automatic logic [31:0] rg(int r, int d);
    return i_swp_rf_model.regs[r][d*32+:32];
  endfunction
  task automatic cmp(logic [31:0] s, logic [31:0] e);
    checks_done++;
    if (s !== e) begin
      num_errors++;
      $display("ERROR %0t seen %h expected %h", $time, s, e);
    end
  endtask
  task automatic conclude();
    if (num_errors == 0 && checks_done > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask
  // Next request is offered in the cycle that shows wb_last_ff, so one idle cycle separates the runs
  task automatic send(swp_mode_t m, swp_fmt_t f, logic [3:0] w,
    logic [15:0] l, logic [7:0] d, logic fe, logic ke, logic [15:0] fo,
    logic [15:0] ko);
    int n;
    req = '{m, f, w, l, d, fe, ke, fo, ko};
    req_valid = 1'b1;
    while (req_ready !== 1'b1) @(negedge clk);
    @(negedge clk);
    req_valid = 1'b0;
    n = 0;
    while (!(wb_valid_ff === 1'b1 && wb_last_ff === 1'b1) && n < 40) begin
      @(negedge clk);
      n++;
    end
    if (n == 40) num_errors++;
    cmp(32'(wb_fmt_ff), 32'(f));
  endtask
  // ********
  // Tests
  // ********
  initial begin
    rst_b = 1'b0;
    req_valid = 1'b0;
    req = '0;
    for (int c = 0; c < 4; c++)
      for (int l = 0; l < 16; l++)
        req_texel[c][l] = t(c, l);
    repeat (3) @(negedge clk);
    rst_b = 1'b1;
    send(SWP_M16, SWP_F_S31, 4'h9, 16'h80f0, 8'h0a, 1, 0, 16'hbeef, 0);
    send(SWP_M8, SWP_F_FLOAT, 4'h5, 16'h000f, 8'h1e, 1, 1, 16'h3c, 16'ha5);
    send(SWP_M4X2, SWP_F_U32, 4'hb, 16'h0020, 8'h32, 1, 0, 16'h2, 0);
    send(SWP_M8, SWP_F_S31, 4'hf, 16'h00ff, 8'h3c, 0, 0, 0, 0);
    send(SWP_M4X2, SWP_F_FLOAT, 4'hf, 16'h0001, 8'h46, 0, 0, 0, 0);
    send(SWP_M16, SWP_F_U32, 4'h0, 16'hffff, 8'h50, 1, 0, 16'h1234, 0);
    send(SWP_M3264, SWP_F_FLOAT, 4'hf, 16'hffff, 8'h5a, 0, 0, 0, 0);
    repeat (2) @(negedge clk);
    cmp(rg(10, 4), t(0, 4));
    cmp(rg(10, 0), K);
    cmp(rg(11, 7), t(0, 15));
    cmp(rg(12, 5), t(3, 5));
    cmp(rg(13, 7), t(3, 15));
    cmp(rg(14, 0), 32'hffffbeef);
    cmp(rg(14, 1), K);
    cmp(rg(30, 2), t(0, 2));
    cmp(rg(31, 0), K);
    cmp(rg(32, 3), t(2, 3));
    cmp(rg(34, 0), 32'hffffffa5);
    cmp(32'(i_swp_rf_model.fixed_mask(34, 16'h0f, 16'hff)), 32'hf5);
    cmp(rg(35, 0), 32'hffffff3c);
    cmp(rg(36, 0), K);
    cmp(rg(50, 4), t(0, 1));
    cmp(rg(50, 7), t(3, 1));
    cmp(rg(50, 6), K);
    cmp(rg(50, 0), K);
    cmp(rg(51, 0), 32'hfffffffe);
    cmp(rg(61, 1), t(1, 1));
    cmp(rg(63, 7), t(3, 7));
    cmp(rg(70, 3), t(3, 0));
    cmp(rg(70, 4), K);
    cmp(rg(90, 0), K);
    cmp(rg(80, 0), 32'hffff1234);
    cmp(rg(81, 0), K);
    conclude();
  end
  initial begin
    #40000;
    num_errors++;
    conclude();
  end
endmodule // test_swp_packer
`default_nettype wire
